// *** lcd_std_pkg.sv ***
// Shared constants for the standard instruction group of the character
// display controller. Assumes one oscillator clock drives both ends.
package lcd_std_pkg;

  // ***********************************************************
  // Instruction encodings
  // ***********************************************************
  localparam logic [7:0] OP_CLEAR     = 8'h01;
  localparam logic [7:0] OP_DISP_BASE = 8'h08;
  localparam logic [7:0] OP_DDR_BASE  = 8'h80;
  localparam int unsigned DISP_BIT_ON = 2;
  localparam int unsigned DISP_BIT_CUR = 1;
  localparam int unsigned DISP_BIT_BLK = 0;

  // ***********************************************************
  // Values and address layout
  // ***********************************************************
  localparam logic [7:0] BLANK_CODE    = 8'h20;
  localparam logic [6:0] LINE1_LAST    = 7'h27;
  localparam logic [6:0] LINE2_FIRST   = 7'h40;
  localparam logic [6:0] LINE2_LAST    = 7'h67;
  localparam logic [6:0] ONE_LINE_LAST = 7'h4f;
  localparam logic [5:0] SHIFT_LAST    = 6'h27;
  localparam int unsigned RAM_WORDS    = 128;
  localparam int unsigned DISP_CHARS   = 80;
  localparam logic [4:0] CURSOR_DOTS   = 5'h1f;

  // ***********************************************************
  // Timing in oscillator cycles
  // ***********************************************************
  localparam int unsigned CLEAR_CYCLES = 165;
  localparam int unsigned HOST_MARGIN  = 2;
  localparam int unsigned OFF_SETTLE   = 3;
  localparam int unsigned BLINK_DIV_CYC = 52224;

endpackage

// *** lcd_std_if.sv ***
// Instruction link between host and display controller.
// Assumes both ends run on the same oscillator clock.
`timescale 1ns/1ns
interface lcd_std_if;
  logic       req;            // One-cycle request pulse
  logic       register_select;
  logic       read_en;
  logic [7:0] wdata;
  logic [7:0] rdata;
  logic       rvalid;         // One-cycle answer pulse

  modport dev  (input req, register_select, read_en, wdata, output rdata, rvalid);
  modport host (output req, register_select, read_en, wdata, input rdata, rvalid);
endinterface

// *** lcd_blink_timer.sv ***
// Blink phase generator for the cursor character.
// Assumes a free-running oscillator clock.
`timescale 1ns/1ns
module lcd_blink_timer #(
  parameter int unsigned DIV = 52224
) (
  // Clock and reset
  input  wire logic clk_sys_i,
  input  wire logic rst_i,
  // Phase
  output logic      phase_o
);
  localparam int unsigned HALF = DIV / 2;
  localparam logic [16:0] HALF_M1 = 17'(HALF - 1);

  logic [16:0] cnt_reg;
  logic [16:0] cnt_next;
  logic        phase_reg;
  logic        phase_next;

  // ***********************************************************
  // Half-period counter
  // ***********************************************************
  // Phase flips every half period, so a full period is DIV cycles
  always_comb
  begin
    cnt_next   = cnt_reg + 17'h00001;
    phase_next = phase_reg;
    if (cnt_reg == HALF_M1)
    begin
      cnt_next   = 17'h00000;
      phase_next = ~phase_reg;
    end
  end

  always_ff @(posedge clk_sys_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      cnt_reg   <= 17'h00000;
      phase_reg <= 1'b0;
    end
    else
    begin
      cnt_reg   <= cnt_next;
      phase_reg <= phase_next;
    end
  end

  assign phase_o = phase_reg;
endmodule

// *** lcd_std_exec.sv ***
// Display controller end: decodes and executes the standard instruction
// group, holds display and glyph RAM. Assumes the host keeps its waits.
// Functional notes
// - Clear fills display RAM with 20h
// - Clear zeroes counter, unshifts, keeps auto-scroll
// - Clear forces increment direction
// - Host waits 165 cycles after clear
// - Host blanks manually where 20h not blank
// - Home zeroes counter and shift only
// - Entry mode steps counter after data access
// - Auto-scroll shifts display on display writes
// - Reads and glyph accesses never auto-scroll
// - Glyph access suppresses cursor and blink
// - Display off powers down, keeps RAM
// - Host waits three cycles before oscillator stop
// - Instructions still run while display off
// - Cursor is five dots on row eight
// - Blink alternates at oscillator over 52224
// - Move/scroll instruction touches no RAM
// - Two-line cursor wraps after position 40
// - Scroll keeps counter, cursor move steps it
// - Glyph pointer loads bits 5-0, keeps 6
// - Host clears counter bit 6 before glyph writes
// - Display pointer loads 7 bits, selects display
// - Standard group only while select bit low
// - Status read gives busy and counter
`timescale 1ns/1ns
module lcd_std_exec
  import lcd_std_pkg::*;
#(
  parameter int unsigned BLINK_DIV = lcd_std_pkg::BLINK_DIV_CYC
) (
  // Clock and reset
  input  wire logic       clk_sys_i,
  input  wire logic       rst_i,
  // Instruction link
  lcd_std_if.dev          bus,
  // Mode inputs
  input  wire logic       ext_set_i,
  input  wire logic       two_line_i,
  // Display RAM scan port
  input  wire logic [6:0] scan_addr_i,
  output logic      [7:0] scan_data_o,
  // Display state
  output logic            display_on_o,
  output logic            power_down_o,
  output logic      [4:0] cursor_dots_o,
  output logic            char_all_on_o,
  output logic      [5:0] shift_offset_o,
  output logic      [6:0] addr_o,
  output logic            glyph_sel_o,
  output logic            busy_o
);
  import lcd_std_pkg::*;

  typedef enum logic {ST_IDLE = 1'b0, ST_CLEAR = 1'b1} state_t;

  state_t      state_reg, state_next;
  logic [7:0]  clr_cnt_reg, clr_cnt_next;
  logic [6:0]  ac_reg, ac_next;
  logic [5:0]  shift_reg, shift_next;
  logic        glyph_reg, glyph_next;
  logic        inc_reg, inc_next;
  logic        scroll_reg, scroll_next;
  logic        disp_reg, disp_next;
  logic        cur_reg, cur_next;
  logic        blk_reg, blk_next;
  logic [7:0]  rdata_reg, rdata_next;
  logic        rvalid_reg, rvalid_next;
  logic [7:0]  scan_reg;
  logic        ram_we, glyph_we;
  logic [6:0]  ram_addr;
  logic [7:0]  ram_wdata;
  logic        blink_phase;
  logic [7:0]  display_ram [RAM_WORDS];
  logic [4:0]  glyph_ram [RAM_WORDS];

  // ***********************************************************
  // Helpers
  // ***********************************************************
  // Display targets wrap per line; glyph targets wrap over 7 bits
  function automatic logic [6:0] ac_step(input logic [6:0] ac, input logic up,
                                         input logic two, input logic glyph);
    logic [6:0] r;
    r = up ? ac + 7'h01 : ac - 7'h01;
    if (!glyph && two)
    begin
      if (up && ac == LINE1_LAST) r = LINE2_FIRST;
      else if (up && ac == LINE2_LAST) r = 7'h00;
      else if (!up && ac == 7'h00) r = LINE2_LAST;
      else if (!up && ac == LINE2_FIRST) r = LINE1_LAST;
    end
    else if (!glyph)
    begin
      if (up && ac == ONE_LINE_LAST) r = 7'h00;
      else if (!up && ac == 7'h00) r = ONE_LINE_LAST;
    end
    return r;
  endfunction

  // One offset for all lines, so characters never spill between lines
  function automatic logic [5:0] shift_move(input logic [5:0] s, input logic left);
    logic [5:0] r;
    if (left)
      r = (s == SHIFT_LAST) ? 6'h00 : s + 6'h01;
    else
      r = (s == 6'h00) ? SHIFT_LAST : s - 6'h01;
    return r;
  endfunction

  // ***********************************************************
  // Instruction execution
  // ***********************************************************
  // Status read is served in every state; other requests only when idle
  always_comb
  begin
    state_next   = state_reg;
    clr_cnt_next = clr_cnt_reg;
    ac_next      = ac_reg;
    shift_next   = shift_reg;
    glyph_next   = glyph_reg;
    inc_next     = inc_reg;
    scroll_next  = scroll_reg;
    disp_next    = disp_reg;
    cur_next     = cur_reg;
    blk_next     = blk_reg;
    rdata_next   = rdata_reg;
    rvalid_next  = 1'b0;
    ram_we       = 1'b0;
    glyph_we     = 1'b0;
    ram_addr     = ac_reg;
    ram_wdata    = bus.wdata;
    if (bus.req && !bus.register_select && bus.read_en)
    begin
      rdata_next  = {(state_reg == ST_CLEAR), ac_reg};
      rvalid_next = 1'b1;
    end
    case (state_reg)
      ST_CLEAR:
      begin
        ram_we       = 1'b1;
        ram_addr     = clr_cnt_reg[6:0];
        ram_wdata    = BLANK_CODE;
        clr_cnt_next = clr_cnt_reg + 8'h01;
        if (clr_cnt_reg == 8'(CLEAR_CYCLES - 1))
          state_next = ST_IDLE;
      end
      ST_IDLE:
      begin
        // Runs whatever the display-on bit is
        if (bus.req && !bus.register_select && !bus.read_en && !ext_set_i)
        begin
          casez (bus.wdata)
            8'b1???????:
            begin
              ac_next    = bus.wdata[6:0];
              glyph_next = 1'b0;
            end
            8'b01??????:
            begin
              ac_next    = {ac_reg[6], bus.wdata[5:0]};
              glyph_next = 1'b1;
            end
            8'b0001????:
            begin
              // No RAM strobe here
              if (bus.wdata[3])
                shift_next = shift_move(shift_reg, ~bus.wdata[2]);
              else
                ac_next = ac_step(ac_reg, bus.wdata[2], two_line_i, glyph_reg);
            end
            8'b00001???:
            begin
              disp_next = bus.wdata[DISP_BIT_ON];
              cur_next  = bus.wdata[DISP_BIT_CUR];
              blk_next  = bus.wdata[DISP_BIT_BLK];
            end
            8'b000001??:
            begin
              inc_next    = bus.wdata[1];
              scroll_next = bus.wdata[0];
            end
            8'b0000001?:
            begin
              ac_next    = 7'h00;
              shift_next = 6'h00;
            end
            8'b00000001:
            begin
              state_next   = ST_CLEAR;
              clr_cnt_next = 8'h00;
              ac_next      = 7'h00;
              shift_next   = 6'h00;
              inc_next     = 1'b1;
            end
            default:
            begin
              ac_next = ac_reg;
            end
          endcase
        end
        else if (bus.req && bus.register_select)
        begin
          ac_next = ac_step(ac_reg, inc_reg, two_line_i, glyph_reg);
          if (bus.read_en)
          begin
            rdata_next  = glyph_reg ? {3'h0, glyph_ram[ac_reg]} : display_ram[ac_reg];
            rvalid_next = 1'b1;
          end
          else if (glyph_reg)
            glyph_we = 1'b1;
          else
          begin
            ram_we = 1'b1;
            if (scroll_reg)
              shift_next = shift_move(shift_reg, inc_reg);
          end
        end
      end
      default:
      begin
        state_next = ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk_sys_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      state_reg   <= ST_IDLE;
      clr_cnt_reg <= 8'h00;
      ac_reg      <= 7'h00;
      shift_reg   <= 6'h00;
      glyph_reg   <= 1'b0;
      inc_reg     <= 1'b1;
      scroll_reg  <= 1'b0;
      disp_reg    <= 1'b0;
      cur_reg     <= 1'b0;
      blk_reg     <= 1'b0;
      rdata_reg   <= 8'h00;
      rvalid_reg  <= 1'b0;
    end
    else
    begin
      state_reg   <= state_next;
      clr_cnt_reg <= clr_cnt_next;
      ac_reg      <= ac_next;
      shift_reg   <= shift_next;
      glyph_reg   <= glyph_next;
      inc_reg     <= inc_next;
      scroll_reg  <= scroll_next;
      disp_reg    <= disp_next;
      cur_reg     <= cur_next;
      blk_reg     <= blk_next;
      rdata_reg   <= rdata_next;
      rvalid_reg  <= rvalid_next;
    end
  end

  // ***********************************************************
  // Memories
  // ***********************************************************
  // No reset on the arrays; contents survive display off
  always_ff @(posedge clk_sys_i)
  begin
    if (ram_we)
      display_ram[ram_addr] <= ram_wdata;
    if (glyph_we)
      glyph_ram[ac_reg] <= bus.wdata[4:0];  // Upper three bits are don't care
    scan_reg <= display_ram[scan_addr_i];
  end

  lcd_blink_timer #(
    .DIV       (BLINK_DIV)
  ) u_blink (
    .clk_sys_i (clk_sys_i),
    .rst_i     (rst_i),
    .phase_o   (blink_phase)
  );

  // ***********************************************************
  // Outputs
  // ***********************************************************
  // Cursor effects are gated off while the pointer targets glyph RAM
  assign cursor_dots_o  = (cur_reg && !glyph_reg) ? CURSOR_DOTS : 5'h00;
  assign char_all_on_o  = blk_reg && !glyph_reg && blink_phase;
  assign display_on_o   = disp_reg;
  assign power_down_o   = ~disp_reg;
  assign shift_offset_o = shift_reg;
  assign addr_o         = ac_reg;
  assign glyph_sel_o    = glyph_reg;
  assign busy_o         = (state_reg == ST_CLEAR);
  assign scan_data_o    = scan_reg;
  assign bus.rdata      = rdata_reg;
  assign bus.rvalid     = rvalid_reg;
endmodule

// *** lcd_std_host.sv ***
// Host end: issues instructions from a user command port, waits out
// the clear time, runs the manual blanking sequence.
`timescale 1ns/1ns
module lcd_std_host
  import lcd_std_pkg::*;
(
  // Clock and reset
  input  wire logic       clk_sys_i,
  input  wire logic       rst_i,
  // Instruction link
  lcd_std_if.host         bus,
  // User commands
  input  wire logic       cmd_valid_i,
  input  wire logic       cmd_rs_i,
  input  wire logic       cmd_read_i,
  input  wire logic [7:0] cmd_data_i,
  output logic            cmd_ready_o,
  // Manual blanking
  input  wire logic       blank_clear_i,
  input  wire logic [7:0] blank_code_i,
  // Responses and status
  output logic            rsp_valid_o,
  output logic      [7:0] rsp_data_o,
  output logic            osc_stop_ok_o
);
  import lcd_std_pkg::*;

  typedef enum logic [2:0] {
    H_IDLE = 3'b000, H_WAIT = 3'b001, H_OFF = 3'b011,
    H_PTR = 3'b010, H_WR = 3'b110, H_ON = 3'b111
  } hstate_t;

  hstate_t     st_reg, st_next;
  logic [7:0]  cnt_reg, cnt_next;
  logic [7:0]  disp_reg, disp_next;
  logic [1:0]  off_reg, off_next;
  logic        ok_reg, ok_next;
  logic        req_reg, req_next;
  logic        rs_reg, rs_next;
  logic        rd_reg, rd_next;
  logic [7:0]  wd_reg, wd_next;
  logic        rspv_reg;
  logic [7:0]  rspd_reg;

  // ***********************************************************
  // Command sequencer
  // ***********************************************************
  // The clear wait is timed, not polled, so it also suits setups without read-back
  always_comb
  begin
    st_next   = st_reg;
    cnt_next  = cnt_reg;
    disp_next = disp_reg;
    req_next  = 1'b0;
    rs_next   = rs_reg;
    rd_next   = rd_reg;
    wd_next   = wd_reg;
    case (st_reg)
      H_IDLE:
      begin
        if (blank_clear_i)
          st_next = H_OFF;
        else if (cmd_valid_i)
        begin
          req_next = 1'b1;
          rs_next  = cmd_rs_i;
          rd_next  = cmd_read_i;
          wd_next  = cmd_data_i;
          if (!cmd_rs_i && !cmd_read_i && cmd_data_i == OP_CLEAR)
          begin
            st_next  = H_WAIT;
            cnt_next = 8'(CLEAR_CYCLES + HOST_MARGIN);
          end
          if (!cmd_rs_i && !cmd_read_i && cmd_data_i[7:3] == OP_DISP_BASE[7:3])
            disp_next = cmd_data_i;
        end
      end
      H_WAIT:
      begin
        cnt_next = cnt_reg - 8'h01;
        if (cnt_reg == 8'h01)
          st_next = H_IDLE;
      end
      H_OFF:
      begin
        req_next = 1'b1;
        rs_next  = 1'b0;
        rd_next  = 1'b0;
        wd_next  = disp_reg & ~(8'h01 << DISP_BIT_ON);
        st_next  = H_PTR;
      end
      H_PTR:
      begin
        req_next = 1'b1;
        wd_next  = OP_DDR_BASE;
        cnt_next = 8'(DISP_CHARS);
        st_next  = H_WR;
      end
      H_WR:
      begin
        // Relies on increment mode and line wrap to visit every cell
        req_next = 1'b1;
        rs_next  = 1'b1;
        wd_next  = blank_code_i;
        cnt_next = cnt_reg - 8'h01;
        if (cnt_reg == 8'h01)
          st_next = H_ON;
      end
      H_ON:
      begin
        req_next  = 1'b1;
        rs_next   = 1'b0;
        wd_next   = disp_reg | (8'h01 << DISP_BIT_ON);
        disp_next = disp_reg | (8'h01 << DISP_BIT_ON);
        st_next   = H_IDLE;
      end
      default:
      begin
        st_next = H_IDLE;
      end
    endcase
  end

  // ***********************************************************
  // Oscillator stop permission
  // ***********************************************************
  // Grants stop only once three cycles have passed since display off
  always_comb
  begin
    off_next = off_reg;
    ok_next  = ok_reg;
    if (disp_reg[DISP_BIT_ON])
    begin
      off_next = 2'h0;
      ok_next  = 1'b0;
    end
    else if (off_reg != 2'(OFF_SETTLE))
      off_next = off_reg + 2'h1;
    else
      ok_next = 1'b1;
  end

  always_ff @(posedge clk_sys_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      st_reg   <= H_IDLE;
      cnt_reg  <= 8'h00;
      disp_reg <= OP_DISP_BASE;
      off_reg  <= 2'h0;
      ok_reg   <= 1'b0;
      req_reg  <= 1'b0;
      rs_reg   <= 1'b0;
      rd_reg   <= 1'b0;
      wd_reg   <= 8'h00;
      rspv_reg <= 1'b0;
      rspd_reg <= 8'h00;
    end
    else
    begin
      st_reg   <= st_next;
      cnt_reg  <= cnt_next;
      disp_reg <= disp_next;
      off_reg  <= off_next;
      ok_reg   <= ok_next;
      req_reg  <= req_next;
      rs_reg   <= rs_next;
      rd_reg   <= rd_next;
      wd_reg   <= wd_next;
      rspv_reg <= bus.rvalid;
      rspd_reg <= bus.rvalid ? bus.rdata : rspd_reg;
    end
  end

  assign cmd_ready_o         = (st_reg == H_IDLE) && !blank_clear_i;
  assign osc_stop_ok_o       = ok_reg;
  assign rsp_valid_o         = rspv_reg;
  assign rsp_data_o          = rspd_reg;
  assign bus.req             = req_reg;
  assign bus.register_select = rs_reg;
  assign bus.read_en         = rd_reg;
  assign bus.wdata           = wd_reg;
endmodule

// *** lcd_std_link_assertions.sv ***
// Checker for the instruction link between host end and display end.
// Assumes one clock and an async active-high reset; sees the link only.
`timescale 1ns/1ns
module lcd_std_link_assertions (
  // Clock and reset
  input  wire logic       clk_sys_i,
  input  wire logic       rst_i,
  // Link signals
  input  wire logic       req,
  input  wire logic       register_select,
  input  wire logic       read_en,
  input  wire logic [7:0] wdata,
  input  wire logic [7:0] rdata,
  input  wire logic       rvalid
);
  logic       ins;
  logic       stat;
  logic       ptr_ok;
  logic       ptr_glyph;
  logic       home_ok;
  logic       off_last;
  logic       fill_on;
  logic [6:0] ptr_val;
  logic [7:0] wait_cnt;
  logic [7:0] fill_cnt;

  // Request kinds seen on the link
  assign ins  = req && !register_select && !read_en;
  assign stat = req && !register_select && read_en;

  // *****
  // Link history
  // *****
  // Any request other than a status read replaces the pointer expectation
  always_ff @(posedge clk_sys_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      {ptr_ok, ptr_glyph, home_ok, off_last, fill_on} <= 5'h00;
      ptr_val  <= 7'h00;
      wait_cnt <= 8'h00;
      fill_cnt <= 8'h00;
    end
    else
    begin
      off_last <= ins && wdata[7:2] == 6'h02;
      if (wait_cnt != 8'h00)
        wait_cnt <= wait_cnt - 8'h01;
      if (ins && wdata == 8'h01)
        wait_cnt <= 8'ha5;
      if (req && !stat)
      begin
        ptr_ok    <= ins && (wdata[7] || wdata[7:6] == 2'h1);
        ptr_glyph <= !wdata[7];
        ptr_val   <= wdata[6:0];
        home_ok   <= ins && wdata[7:2] == 6'h00 && wdata[1:0] != 2'h0;
      end
      if (ins && wdata == 8'h80 && off_last)
      begin
        fill_on  <= 1'b1;
        fill_cnt <= 8'h00;
      end
      else if (fill_on && req && register_select)
        fill_cnt <= fill_cnt + 8'h01;
      else if (fill_on && ins)
        fill_on <= 1'b0;
    end
  end

  // *****
  // Properties
  // *****
  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (rst_i);

  sequence blank_start;
    (ins && wdata[7:2] == 6'h02) ##1 (ins && wdata == 8'h80);
  endsequence
  sequence fill_run;
    (req && register_select && !read_en)[*8];
  endsequence

  a_read_answer: assert property (req && read_en |=> rvalid)
    else $error("Read request got no answer");
  a_answer_cause: assert property (rvalid |-> $past(req && read_en))
    else $error("Answer without a read request");
  a_write_silent: assert property (req && !read_en |=> !rvalid)
    else $error("Write request produced an answer");
  a_clear_wait: assert property (req |-> wait_cnt == 8'h00)
    else $error("Request sent during clear time");
  a_home_status: assert property (stat && home_ok |=> rdata == 8'h00)
    else $error("Counter not zero after clear or home");
  a_display_ptr: assert property (stat && ptr_ok && !ptr_glyph |=> rdata[6:0] == ptr_val)
    else $error("Display pointer not loaded");
  a_glyph_ptr: assert property (stat && ptr_ok && ptr_glyph |=> rdata[5:0] == ptr_val[5:0])
    else $error("Glyph pointer not loaded");
  a_blank_fill: assert property (blank_start |=> fill_run)
    else $error("Blank fill not written back to back");
  a_blank_count: assert property (fill_on && ins |-> fill_cnt == 8'h50 && wdata[7:2] == 6'h03)
    else $error("Blank fill count or display-on step wrong");
endmodule

// *** tb_lcd_standard_instruction_exec.sv ***
// Testbench joining host end and display end through the link.
// Assumes a 100 MHz clock and the short blink divider set below.
`timescale 1ns/1ns
module tb_lcd_standard_instruction_exec;
  import lcd_std_pkg::*;
  logic       clk_sys_i, rst_i, ext_set_i, two_line_i, blank_clear_i;
  logic       cmd_valid_i, cmd_rs_i, cmd_read_i, cmd_ready_o, rsp_valid_o;
  logic       display_on_o, power_down_o, char_all_on_o, glyph_sel_o, busy_o;
  logic       osc_stop_ok_o;
  logic [7:0] cmd_data_i, blank_code_i, rsp_data_o, scan_data_o, got;
  logic [6:0] scan_addr_i, addr_o;
  logic [5:0] shift_offset_o;
  logic [4:0] cursor_dots_o;
  int         bad_count, checked, cycles;

  // *****
  // Design and checker
  // *****
  lcd_std_if link ();
  lcd_std_exec #(.BLINK_DIV(16)) u_lcd_std_exec (.clk_sys_i, .rst_i, .bus(link), .ext_set_i,
    .two_line_i, .scan_addr_i, .scan_data_o, .display_on_o, .power_down_o, .cursor_dots_o,
    .char_all_on_o, .shift_offset_o, .addr_o, .glyph_sel_o, .busy_o);
  lcd_std_host u_lcd_std_host (.clk_sys_i, .rst_i, .bus(link), .cmd_valid_i, .cmd_rs_i,
    .cmd_read_i, .cmd_data_i, .cmd_ready_o, .blank_clear_i, .blank_code_i, .rsp_valid_o,
    .rsp_data_o, .osc_stop_ok_o);
  lcd_std_link_assertions u_lcd_std_link_assertions (.clk_sys_i, .rst_i, .req(link.req),
    .register_select(link.register_select), .read_en(link.read_en), .wdata(link.wdata),
    .rdata(link.rdata), .rvalid(link.rvalid));

  // Free-running clock and hang guard
  initial
  begin
    clk_sys_i = 1'b0;
    forever #5 clk_sys_i = ~clk_sys_i;
  end
  always @(posedge clk_sys_i)
  begin
    cycles++;
    if (cycles == 20000)
    begin
      bad_count++;
      summarize();
    end
  end

  // *****
  // Shared tasks
  // *****
  task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] seen);
    checked++;
    if (seen !== exp)
    begin
      bad_count++;
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
    end
  endtask

  // Holds the command until the host takes it, then gathers any answer
  task automatic send(input logic rs, input logic rd, input logic [7:0] d);
    logic ok;
    int   n;
    n = 0;
    @(posedge clk_sys_i);
    {cmd_valid_i, cmd_rs_i, cmd_read_i, cmd_data_i} <= {1'b1, rs, rd, d};
    do
    begin
      #1 ok = cmd_ready_o;
      @(posedge clk_sys_i);
      n++;
    end
    while (ok !== 1'b1 && n < 400);
    cmd_valid_i <= 1'b0;
    if (n >= 400)
      chk("ready", 8'h01, 8'h00);
    got = 8'hxx;
    repeat (8)
    begin
      @(posedge clk_sys_i);
      #1 if (rsp_valid_o === 1'b1) got = rsp_data_o;
    end
  endtask

  // Scan port has one cycle of latency
  task automatic scan(input logic [6:0] a, input logic [7:0] exp);
    @(posedge clk_sys_i);
    scan_addr_i <= a;
    repeat (2) @(posedge clk_sys_i);
    #1 chk("scan", exp, scan_data_o);
  endtask

  // *****
  // Scenarios
  // *****
  task automatic s_clear;
    send(0, 0, 8'h85);
    send(0, 0, 8'h05);
    send(1, 0, 8'h41);
    send(0, 0, OP_CLEAR);
    chk("busy", 8'h01, {7'h00, busy_o});
    send(0, 1, 8'h00);
    chk("status", 8'h00, got);
    chk("shift", 8'h00, {2'h0, shift_offset_o});
    scan(7'h05, BLANK_CODE);
    send(1, 0, 8'h42);
    chk("addr", 8'h01, {1'b0, addr_o});
    chk("shift", 8'h01, {2'h0, shift_offset_o});
  endtask

  task automatic s_home;
    send(0, 0, 8'h03);
    chk("addr", 8'h00, {1'b0, addr_o});
    chk("shift", 8'h00, {2'h0, shift_offset_o});
    scan(7'h00, 8'h42);
    send(1, 0, 8'h55);
    chk("shift", 8'h01, {2'h0, shift_offset_o});
    send(0, 0, 8'h04);
    send(0, 0, 8'h8a);
    send(1, 0, 8'h33);
    chk("addr", 8'h09, {1'b0, addr_o});
    send(0, 0, 8'h07);
    send(1, 1, 8'h00);
    chk("rdata", BLANK_CODE, got);
    chk("addr", 8'h0a, {1'b0, addr_o});
    chk("shift", 8'h01, {2'h0, shift_offset_o});
    send(0, 0, 8'h00);
    chk("addr", 8'h0a, {1'b0, addr_o});
  endtask

  task automatic s_move;
    send(0, 0, 8'ha7);
    send(0, 0, 8'h14);
    chk("addr", 8'h40, {1'b0, addr_o});
    send(0, 0, 8'h18);
    chk("addr", 8'h40, {1'b0, addr_o});
    chk("shift", 8'h02, {2'h0, shift_offset_o});
    send(0, 0, 8'h85);
    send(0, 0, 8'h10);
    chk("addr", 8'h04, {1'b0, addr_o});
  endtask

  task automatic s_glyph;
    send(0, 0, 8'h0e);
    chk("cursor", {3'h0, CURSOR_DOTS}, {3'h0, cursor_dots_o});
    send(0, 0, 8'hc5);
    send(0, 0, 8'h43);
    send(0, 1, 8'h00);
    chk("status", 8'h43, got);
    chk("glyph", 8'h01, {7'h00, glyph_sel_o});
    chk("cursor", 8'h00, {3'h0, cursor_dots_o});
    send(1, 0, 8'h1f);
    chk("shift", 8'h02, {2'h0, shift_offset_o});
    // Display pointer first, so bit 6 is clear for the lower glyph half
    send(0, 0, OP_DDR_BASE);
    send(0, 0, 8'h4a);
    send(0, 1, 8'h00);
    chk("status", 8'h0a, got);
    send(1, 0, 8'h15);
    send(0, 0, 8'h4a);
    send(1, 1, 8'h00);
    chk("glyphdata", 8'h15, got);
    send(0, 0, OP_DDR_BASE);
    chk("glyph", 8'h00, {7'h00, glyph_sel_o});
  endtask

  task automatic s_power;
    int n;
    n = 0;
    @(posedge clk_sys_i);
    ext_set_i <= 1'b1;
    send(0, 0, OP_DISP_BASE);
    chk("display", 8'h01, {7'h00, display_on_o});
    @(posedge clk_sys_i);
    ext_set_i <= 1'b0;
    send(0, 0, 8'h0d);
    repeat (64)
    begin
      @(posedge clk_sys_i);
      #1 if (char_all_on_o === 1'b1) n++;
    end
    chk("blink", 8'h20, n[7:0]);
    send(0, 0, OP_DISP_BASE);
    chk("powerdown", 8'h01, {6'h00, display_on_o, power_down_o});
    chk("oscstop", 8'h01, {7'h00, osc_stop_ok_o});
    send(0, 0, 8'h92);
    send(0, 1, 8'h00);
    chk("status", 8'h12, got);
    scan(7'h00, 8'h55);
  endtask

  task automatic s_blank;
    send(0, 0, 8'h06);
    @(posedge clk_sys_i);
    blank_clear_i <= 1'b1;
    @(posedge clk_sys_i);
    blank_clear_i <= 1'b0;
    send(0, 1, 8'h00);
    chk("status", 8'h00, got);
    chk("display", 8'h01, {7'h00, display_on_o});
    scan(7'h00, 8'h5f);
    scan(7'h67, 8'h5f);
  endtask

  // Verdict and end of run
  task automatic summarize;
    $display("Checks %0d mismatches %0d", checked, bad_count);
    if (bad_count == 0 && checked > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  // Main sequence
  initial
  begin
    {rst_i, ext_set_i, two_line_i, blank_clear_i, cmd_valid_i} = 5'h14;
    {cmd_rs_i, cmd_read_i, cmd_data_i, scan_addr_i} = 17'h00000;
    blank_code_i = 8'h5f;
    repeat (3) @(posedge clk_sys_i);
    rst_i <= 1'b0;
    s_clear();
    s_home();
    s_move();
    s_glyph();
    s_power();
    s_blank();
    summarize();
  end
endmodule
